// *** pfc_pkg.sv ***
// constants and types shared by the port logic clock and reset front end
package pfc_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam logic [11:0] CTL_OFFSET = 12'h000;
  localparam logic [11:0] SYNC_OFFSET = 12'h004;
  localparam logic [11:0] STATUS_OFFSET = 12'h008;

  // fabric control register fields
  localparam int CTL_SRC_LSB = 8;
  localparam int CTL_SRC_MSB = 12;
  localparam int CTL_EN_BIT = 31;
  localparam logic [31:0] CTL_WRITE_MASK = 32'h80001F00;
  // reset leaves the fabric disabled on a constant-zero source
  localparam logic [31:0] CTL_RESET = 32'h00001400;

  // synchronizer enable register: pins low byte, router byte above
  localparam int SYNC_PIN_LSB = 0;
  localparam int SYNC_ROUTER_LSB = 8;
  localparam logic [31:0] SYNC_WRITE_MASK = 32'h0000FFFF;
  localparam logic [31:0] SYNC_RESET = 32'h00000000;

  // status register fields
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_RESET_N_BIT = 4;
  localparam int STAT_BYPASS_BIT = 5;
  localparam int STAT_LEVEL_BIT = 6;
  localparam int STAT_COUNT_LSB = 8;

  // ----------------------------------------------------------------
  // clock and reset source codes
  // ----------------------------------------------------------------
  localparam logic [4:0] SRC_PIN_FIRST = 5'h00;
  localparam logic [4:0] SRC_ROUTER_FIRST = 5'h08;
  localparam logic [4:0] SRC_PERIPH_ACTIVE = 5'h10;
  localparam logic [4:0] SRC_PERIPH_ALL = 5'h11;
  localparam logic [4:0] SRC_SLOW = 5'h13;
  localparam logic [4:0] SRC_SYSTEM = 5'h1F;

  // fabric clock edges held in reset and bypass after enable
  localparam logic [1:0] STARTUP_TICKS = 2'h2;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PWR_ACTIVE = 2'h0,
    PWR_SLEEP = 2'h1,
    PWR_DEEP_SLEEP = 2'h2
  } pfc_power_t;

  typedef enum logic [2:0] {
    ST_OFF = 3'h1,
    ST_START = 3'h2,
    ST_RUN = 3'h4
  } pfc_state_t;

endpackage

// *** pfc_sync_bank.sv ***
// two-stage input synchronizers advanced by the fabric clock, each bypassable
`timescale 1ns/1ps

module pfc_sync_bank (
  input wire logic clk,
  input wire logic reset,
  input wire logic fabric_tick,
  input wire logic [15:0] raw_in,
  input wire logic [15:0] sync_en,
  output logic [15:0] data_out
);

  logic [15:0] stage1_q;
  logic [15:0] stage2_q;
  logic [15:0] data_q;
  wire [15:0] data_d;

  // ----------------------------------------------------------------
  // synchronizer chain
  // ----------------------------------------------------------------
  // both stages move only on a fabric clock edge, so latency is two fabric clocks
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      stage1_q <= 16'h0000;
      stage2_q <= 16'h0000;
    end else if (fabric_tick) begin
      stage1_q <= raw_in;
      stage2_q <= stage1_q;
    end
  end

  // per-input choice between direct and synchronized path
  assign data_d = (sync_en & stage2_q) | (~sync_en & raw_in);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      data_q <= 16'h0000;
    end else begin
      data_q <= data_d;
    end
  end

  assign data_out = data_q;

endmodule // pfc_sync_bank

// *** pfc_clock_front.sv ***
// clock, reset and input synchronizer front end of the port logic fabric
//
// The implementer's own choices: register access over APB and the address map.
`timescale 1ns/1ps

module pfc_clock_front (
  input wire logic clk,
  input wire logic reset,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] pin_in,
  input wire logic [7:0] router_in,
  input wire logic periph_div_clk,
  input wire logic low_frequency_clock,
  input wire logic slow_clock_deep_sleep_reset_n,
  input wire pfc_pkg::pfc_power_t power_mode,
  output logic fabric_clk,
  output logic fabric_tick,
  output logic fabric_reset_n,
  output logic fabric_bypass,
  output logic [7:0] pin_data,
  output logic [7:0] router_data
);

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  // codes whose clock is constant zero: 18 and 20 to 30
  function automatic logic src_is_zero(input logic [4:0] code);
    src_is_zero = (code == 5'h12) || ((code >= 5'h14) && (code <= 5'h1E));
  endfunction

  // codes driven by the divided peripheral clock
  function automatic logic src_is_periph(input logic [4:0] code);
    src_is_periph = (code == pfc_pkg::SRC_PERIPH_ACTIVE) || (code == pfc_pkg::SRC_PERIPH_ALL);
  endfunction

  // ----------------------------------------------------------------
  // pin and foreign-clock input synchronizers
  // ----------------------------------------------------------------
  // every level from outside clk crosses two flops first; fabric logic sees only sync_q
  logic [18:0] meta_q;
  logic [18:0] sync_q;
  wire [18:0] async_in;

  assign async_in = {slow_clock_deep_sleep_reset_n, low_frequency_clock, periph_div_clk, router_in, pin_in};

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      meta_q <= 19'h40000;
      sync_q <= 19'h40000;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  wire [7:0] pin_s = sync_q[7:0];
  wire [7:0] router_s = sync_q[15:8];
  wire periph_s = sync_q[16];
  wire slow_clk_s = sync_q[17];
  wire slow_rst_n_s = sync_q[18];

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [31:0] ctl_q;
  logic [31:0] sync_ctl_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;

  // source code and enable decoded straight from the control register
  wire [4:0] src = ctl_q[pfc_pkg::CTL_SRC_MSB:pfc_pkg::CTL_SRC_LSB];
  wire enable = ctl_q[pfc_pkg::CTL_EN_BIT];

  // ----------------------------------------------------------------
  // source selection
  // ----------------------------------------------------------------
  logic sys_phase_q;
  logic level_prev_q;
  logic src_level;
  logic src_reset;

  // per-class decode of the source code and power mode
  wire periph_avail = (power_mode == pfc_pkg::PWR_ACTIVE) || (power_mode == pfc_pkg::PWR_SLEEP);
  wire is_pin = (src < pfc_pkg::SRC_ROUTER_FIRST);
  wire is_router = (src >= pfc_pkg::SRC_ROUTER_FIRST) && (src < pfc_pkg::SRC_PERIPH_ACTIVE);
  wire is_system = (src == pfc_pkg::SRC_SYSTEM);

  // one clock level and its paired reset for the whole fabric
  always_comb begin
    src_level = 1'b0;
    src_reset = 1'b0;
    if (is_pin) begin
      src_level = pin_s[src[2:0]];
    end else if (is_router) begin
      src_level = router_s[src[2:0]];
    end else if (src_is_periph(src)) begin
      src_level = periph_s & periph_avail;
      src_reset = (src == pfc_pkg::SRC_PERIPH_ACTIVE) && (power_mode != pfc_pkg::PWR_ACTIVE);
    end else if (src == pfc_pkg::SRC_SLOW) begin
      src_level = slow_clk_s;
      src_reset = ~slow_rst_n_s;
    end else if (is_system) begin
      src_level = sys_phase_q;
    end else if (src_is_zero(src)) begin
      src_level = 1'b0;
    end
  end

  // a fabric clock edge is a rising level; the system code ticks on every clk
  // limitation: the level is sampled once per clk, so a high or low phase
  // shorter than one clk can be missed and that fabric edge is lost
  wire tick_raw = is_system ? 1'b1 : (src_level & ~level_prev_q);
  wire tick_d = enable & tick_raw;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sys_phase_q <= 1'b0;
      level_prev_q <= 1'b0;
    end else begin
      sys_phase_q <= ~sys_phase_q;
      level_prev_q <= src_level;
    end
  end

  // ----------------------------------------------------------------
  // enable and start-up sequence
  // ----------------------------------------------------------------
  pfc_pkg::pfc_state_t state_q;
  pfc_pkg::pfc_state_t state_d;
  logic [1:0] count_q;
  logic [1:0] count_d;

  // stale synchronizer contents are hidden for two fabric edges after enable
  always_comb begin
    state_d = state_q;
    count_d = count_q;
    case (state_q)
      pfc_pkg::ST_OFF: begin
        count_d = 2'h0;
        if (enable) begin
          state_d = pfc_pkg::ST_START;
        end
      end
      pfc_pkg::ST_START: begin
        if (!enable) begin
          state_d = pfc_pkg::ST_OFF;
        end else if (tick_d) begin
          count_d = 2'(count_q + 2'h1);
          if (count_d == pfc_pkg::STARTUP_TICKS) begin
            state_d = pfc_pkg::ST_RUN;
          end
        end
      end
      pfc_pkg::ST_RUN: begin
        if (!enable) begin
          state_d = pfc_pkg::ST_OFF;
        end
      end
      default: begin
        state_d = pfc_pkg::ST_OFF;
        count_d = 2'h0;
      end
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_q <= pfc_pkg::ST_OFF;
      count_q <= 2'h0;
    end else begin
      state_q <= state_d;
      count_q <= count_d;
    end
  end

  // ----------------------------------------------------------------
  // fabric clock and reset outputs
  // ----------------------------------------------------------------
  logic fabric_clk_q;
  logic fabric_tick_q;
  logic fabric_reset_n_q;
  logic fabric_bypass_q;

  wire running = (state_d == pfc_pkg::ST_RUN);
  wire fabric_clk_d = enable & src_level;
  wire fabric_reset_n_d = running & ~src_reset;
  wire fabric_bypass_d = ~running;

  // one registered clock, tick and reset leave for the fabric; the fabric input synchronizers here step on the unregistered tick_d
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      fabric_clk_q <= 1'b0;
      fabric_tick_q <= 1'b0;
      fabric_reset_n_q <= 1'b0;
      fabric_bypass_q <= 1'b1;
    end else begin
      fabric_clk_q <= fabric_clk_d;
      fabric_tick_q <= tick_d;
      fabric_reset_n_q <= fabric_reset_n_d;
      fabric_bypass_q <= fabric_bypass_d;
    end
  end

  assign fabric_clk = fabric_clk_q;
  assign fabric_tick = fabric_tick_q;
  assign fabric_reset_n = fabric_reset_n_q;
  assign fabric_bypass = fabric_bypass_q;

  // ----------------------------------------------------------------
  // fabric input synchronizers
  // ----------------------------------------------------------------
  wire [15:0] bank_out;
  wire [15:0] bank_en = sync_ctl_q[15:0];

  pfc_sync_bank u_sync_bank (
    .clk(clk),
    .reset(reset),
    .fabric_tick(tick_d),
    .raw_in(sync_q[15:0]),
    .sync_en(bank_en),
    .data_out(bank_out)
  );

  assign pin_data = bank_out[7:0];
  assign router_data = bank_out[15:8];

  // ----------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------
  // no wait state: pready rises in the first access cycle, so reads come from flops
  wire setup = psel & ~penable;
  wire access = psel & penable & pready_q;
  wire hit_ctl = (paddr == pfc_pkg::CTL_OFFSET);
  wire hit_sync = (paddr == pfc_pkg::SYNC_OFFSET);
  wire hit_status = (paddr == pfc_pkg::STATUS_OFFSET);
  wire hit_any = hit_ctl | hit_sync | hit_status;
  wire wr_ctl = access & pwrite & hit_ctl;
  wire wr_sync = access & pwrite & hit_sync;

  // status is read-only; a write to it is ignored without an error
  wire [31:0] status_word = {16'h0000, 6'h00, count_q, 1'b0, src_level, fabric_bypass_q, fabric_reset_n_q,
                             1'b0, state_q};
  wire [31:0] read_mux = hit_ctl ? ctl_q : hit_sync ? sync_ctl_q : hit_status ? status_word : 32'h00000000;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ctl_q <= pfc_pkg::CTL_RESET;
      sync_ctl_q <= pfc_pkg::SYNC_RESET;
    end else begin
      if (wr_ctl) begin
        ctl_q <= pwdata & pfc_pkg::CTL_WRITE_MASK;
      end
      if (wr_sync) begin
        sync_ctl_q <= pwdata & pfc_pkg::SYNC_WRITE_MASK;
      end
    end
  end

  // answer is prepared in the setup cycle and held through the access cycle
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end else begin
      pready_q <= setup;
      pslverr_q <= setup & ~hit_any;
      prdata_q <= (setup & ~pwrite) ? read_mux : 32'h00000000;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

endmodule // pfc_clock_front

// *** pfc_clock_front_asserts.sv ***
// port-level assertions for the port logic clock and reset front end
`timescale 1ns/1ps
module pfc_clock_front_asserts (
  input wire logic clk,
  input wire logic reset,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire pfc_pkg::pfc_power_t power_mode,
  input wire logic fabric_clk,
  input wire logic fabric_tick,
  input wire logic fabric_reset_n,
  input wire logic fabric_bypass
);
  // ----------------------------------------------------------------
  // shadow of the control register and start-up tick count
  // ----------------------------------------------------------------
  logic [31:0] ctl_q;
  logic [1:0] cnt_q;
  logic [1:0] en_hist_q;
  wire ctl_wr = psel && penable && pready && pwrite && paddr == pfc_pkg::CTL_OFFSET;
  wire en = ctl_q[pfc_pkg::CTL_EN_BIT];
  wire [4:0] src = ctl_q[pfc_pkg::CTL_SRC_MSB:pfc_pkg::CTL_SRC_LSB];
  wire zero_src = src == 5'h12 || (src >= 5'h14 && src <= 5'h1E);
  wire free_src = src < 5'h10 || src == pfc_pkg::SRC_PERIPH_ALL || src == pfc_pkg::SRC_SYSTEM;
  wire periph_src = src[4:1] == 4'h8;
  // count saturates so a long run never wraps back to one; a tick seen on the port in the
  // first two cycles after the enable write was made before start-up began, so it is skipped
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ctl_q <= pfc_pkg::CTL_RESET;
      cnt_q <= 2'h0;
      en_hist_q <= 2'h0;
    end else begin
      en_hist_q <= {en_hist_q[0], en};
      if (ctl_wr) ctl_q <= pwdata & pfc_pkg::CTL_WRITE_MASK;
      if (!en) cnt_q <= 2'h0;
      else if (fabric_tick && en_hist_q[1] && cnt_q != 2'h3) cnt_q <= cnt_q + 2'h1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  a_apb_answer: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("access phase not answered in one cycle");
  a_apb_error: assert property (pready |-> pslverr == !(paddr inside {12'h000, 12'h004, 12'h008}))
    else $error("slave error does not match the address map");
  a_run_released: assert property (fabric_reset_n |-> !fabric_bypass)
    else $error("fabric reset released while in bypass");
  a_startup_count: assert property ($fell(fabric_bypass) |-> en && fabric_tick && cnt_q == 2'h1)
    else $error("bypass left after a wrong number of fabric ticks");
  a_off_gated: assert property ((!en) [*2] |-> !fabric_clk && !fabric_tick && !fabric_reset_n && fabric_bypass)
    else $error("disabled fabric still clocked or out of reset");
  a_zero_quiet: assert property ((zero_src) [*2] |-> !fabric_tick && !fabric_clk)
    else $error("constant-zero source produced a clock");
  a_no_reset_src: assert property ((free_src && !fabric_bypass) [*2] |-> fabric_reset_n)
    else $error("source without reset held the fabric in reset");
  a_active_only: assert property ((src == 5'h10 && power_mode != pfc_pkg::PWR_ACTIVE) [*2] |-> !fabric_reset_n)
    else $error("active-only source not in reset outside Active");
  a_deep_no_tick: assert property ((periph_src && power_mode == pfc_pkg::PWR_DEEP_SLEEP) [*4] |-> !fabric_tick)
    else $error("divided clock ticked in Deep-Sleep");
  c_startup: cover property ($fell(fabric_bypass));
  c_slverr: cover property (pready && pslverr);
  c_slow_run: cover property (fabric_reset_n && src == pfc_pkg::SRC_SLOW);
endmodule // pfc_clock_front_asserts

bind pfc_clock_front pfc_clock_front_asserts chk_i (.clk, .reset, .paddr, .psel, .penable, .pwrite, .pwdata,
  .pready, .pslverr, .power_mode, .fabric_clk, .fabric_tick, .fabric_reset_n, .fabric_bypass);

// *** pfc_far_model.sv ***
// far-side model: port pins, router lines, divided and slow clocks
`timescale 1ns/1ps
module pfc_far_model #(
  parameter int DIV_HALF = 3,
  parameter int LF_HALF = 9
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] pin_lvl,
  input wire logic [7:0] router_lvl,
  input wire logic periph_run,
  input wire logic slow_rst_n,
  output logic [7:0] pin_in,
  output logic [7:0] router_in,
  output logic periph_div_clk,
  output logic low_frequency_clock,
  output logic slow_clock_deep_sleep_reset_n
);
  int div_q;
  int lf_q;
  // lines move just after the system edge; the slow clock runs free, even in Deep-Sleep
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pin_in <= 8'h00;
      router_in <= 8'h00;
      periph_div_clk <= 1'b0;
      low_frequency_clock <= 1'b0;
      slow_clock_deep_sleep_reset_n <= 1'b0;
      div_q <= 0;
      lf_q <= 0;
    end else begin
      pin_in <= pin_lvl;
      router_in <= router_lvl;
      slow_clock_deep_sleep_reset_n <= slow_rst_n;
      div_q <= (div_q == DIV_HALF - 1) ? 0 : div_q + 1;
      lf_q <= (lf_q == LF_HALF - 1) ? 0 : lf_q + 1;
      if (periph_run && div_q == DIV_HALF - 1) periph_div_clk <= ~periph_div_clk;
      if (lf_q == LF_HALF - 1) low_frequency_clock <= ~low_frequency_clock;
    end
  end
endmodule // pfc_far_model

// *** pfc_clock_front_tb_top.sv ***
// self-checking bench of the port logic clock and reset front end
`timescale 1ns/1ps
module pfc_clock_front_tb_top;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [11:0] paddr = 12'h000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready, pslverr, fabric_clk, fabric_tick, fabric_reset_n, fabric_bypass;
  logic [7:0] pin_in, router_in, pin_data, router_data;
  logic [7:0] pin_lvl = 8'h00;
  logic [7:0] router_lvl = 8'h00;
  logic periph_div_clk, low_frequency_clock, slow_clock_deep_sleep_reset_n;
  logic periph_run = 1'b1;
  logic slow_rst_n = 1'b0;
  pfc_pkg::pfc_power_t power_mode = pfc_pkg::PWR_ACTIVE;
  int error_cnt = 0;
  int n_checks = 0;
  int ticks = 0;
  int cyc = 0;
  logic [31:0] rd;
  logic err;
  pfc_clock_front uut (.clk, .reset, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
    .pin_in, .router_in, .periph_div_clk, .low_frequency_clock, .slow_clock_deep_sleep_reset_n, .power_mode,
    .fabric_clk, .fabric_tick, .fabric_reset_n, .fabric_bypass, .pin_data, .router_data);
  pfc_far_model far (.clk, .reset, .pin_lvl, .router_lvl, .periph_run, .slow_rst_n, .pin_in, .router_in,
    .periph_div_clk, .low_frequency_clock, .slow_clock_deep_sleep_reset_n);
  always #4 clk = ~clk;
  // tick tally and hang guard; the whole run needs well under this many cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (fabric_tick === 1'b1) ticks <= ticks + 1;
    if (cyc == 20000) begin
      error_cnt++;
      final_report();
    end
  end
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    // no cycle count is assumed here; only the bench timeout ends a hung wait
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic src(input logic [4:0] code, input logic en);
    apb(1'b1, 12'h000, {en, 18'h00000, code, 8'h00});
  endtask
  task automatic cw(input int n);
    repeat (n) @(posedge clk);
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, pfc_pkg::CTL_RESET);
    apb(1'b1, 12'h000, 32'h7FFFF3FF);
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h00001300);
    apb(1'b0, 12'h004, 32'h0);
    chk(rd, pfc_pkg::SYNC_RESET);
    apb(1'b1, 12'h00C, 32'hFFFFFFFF);
    chk({31'h0, err}, 32'h1);
    apb(1'b1, 12'h008, 32'hFFFFFFFF);
    chk({31'h0, err}, 32'h0);
    apb(1'b0, 12'h008, 32'h0);
    chk(rd & 32'h0000033F, 32'h00000021);
    $display("test registers done");
  endtask
  task automatic t_sys();
    int n;
    n = 0;
    src(5'h1F, 1'b1);
    while (fabric_reset_n !== 1'b1 && n < 20) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(n, 3);
    chk({31'h0, fabric_bypass}, 32'h0);
    $display("test system clock done");
  endtask
  // pin 0 synchronized against router 0 direct, then the other way round
  task automatic t_sync();
    int n;
    int m;
    for (int k = 0; k < 2; k++) begin
      apb(1'b1, 12'h004, k == 0 ? 32'h00000001 : 32'h00000100);
      @(posedge clk);
      pin_lvl <= k == 0 ? 8'h01 : 8'h00;
      router_lvl <= k == 0 ? 8'h01 : 8'h00;
      n = 0;
      m = 0;
      repeat (20) begin
        @(posedge clk);
        #1;
        n += (pin_data[0] !== pin_lvl[0]);
        m += (router_data[0] !== router_lvl[0]);
      end
      chk(k == 0 ? n - m : m - n, 2);
    end
    src(5'h14, 1'b0);
    @(posedge clk);
    #1;
    chk({29'h0, fabric_clk, fabric_reset_n, fabric_tick}, 32'h0);
    $display("test synchronizers done");
  endtask
  // every pin and router code, toggling only the line it should pick, then the constant-zero codes with every pin toggling
  task automatic t_codes();
    int t0;
    for (int c = 0; c < 31; c++) begin
      if (c != 16 && c != 17 && c != 19) begin
        src(5'h14, 1'b0);
        src(c[4:0], 1'b1);
        t0 = ticks;
        repeat (6) begin
          cw(6);
          if (c < 8) pin_lvl[c] <= ~pin_lvl[c];
          else if (c < 16) router_lvl[c - 8] <= ~router_lvl[c - 8];
          else pin_lvl <= ~pin_lvl;
        end
        cw(8);
        chk(ticks - t0, c < 16 ? 3 : 0);
        chk({31'h0, fabric_reset_n}, c < 16 ? 32'h1 : 32'h0);
      end
    end
    $display("test source codes done");
  endtask
  // divided clock: reset outside Active for code 16, stopped in Deep-Sleep even while it toggles
  task automatic t_periph();
    int t0;
    src(5'h14, 1'b0);
    src(5'h10, 1'b1);
    cw(40);
    chk({31'h0, fabric_reset_n}, 32'h1);
    power_mode <= pfc_pkg::PWR_SLEEP;
    cw(4);
    chk({31'h0, fabric_reset_n}, 32'h0);
    src(5'h14, 1'b0);
    src(5'h11, 1'b1);
    cw(40);
    chk({31'h0, fabric_reset_n}, 32'h1);
    power_mode <= pfc_pkg::PWR_DEEP_SLEEP;
    cw(6);
    t0 = ticks;
    cw(40);
    chk(ticks - t0, 0);
    chk({31'h0, fabric_reset_n}, 32'h1);
    $display("test divided clock done");
  endtask
  task automatic t_slow();
    src(5'h14, 1'b0);
    src(5'h13, 1'b1);
    cw(80);
    chk({30'h0, fabric_reset_n, fabric_bypass}, 32'h0);
    slow_rst_n <= 1'b1;
    cw(80);
    chk({30'h0, fabric_reset_n, fabric_bypass}, 32'h2);
    $display("test slow clock done");
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    cw(12);
    reset <= 1'b0;
    t_regs();
    t_sys();
    t_sync();
    t_codes();
    t_periph();
    t_slow();
    final_report();
  end
endmodule // pfc_clock_front_tb_top
